// ==== rtl/udi_device.sv ====
// Interrupt unit of a full-speed USB device controller, device end of the local bus.
// Function
// [RULE_01] Eight sticky cause bits, fixed bit assignment.
// [RULE_02] Per-bit enable register, one enables cause.
// [RULE_03] Cause bit reads zero while disabled.
// [RULE_04] Interrupt active while any cause bit set.
// [RULE_05] Stored setup sets flag and cause together.
// [RULE_06] Writing one to setup flag clears both.
// [RULE_07] After reset only setup enable is set.
// [RULE_08] Stored receive packet sets flag and cause.
// [RULE_09] Writing one to receive flag clears both.
// [RULE_10] Packet completes on end-of-packet, any size.
// [RULE_11] Receive flags 0,1,2 map to causes 3,1,2.
// [RULE_12] Transmit FIFO ready clears flag, sets cause.
// [RULE_13] Writing one arms transmit flag, clears cause.
// [RULE_14] Armed flag sends packet, short ones too.
// [RULE_15] Transmit flags 4..7 map to causes 4,1,2,7.
// [RULE_16] SE0 for 2.5 us sets bus-reset cause.
// [RULE_17] Writing one to state bit 5 clears it.
// [RULE_18] Idle for 3 ms enters suspend, sets cause.
// [RULE_19] Resume or bus reset clears suspend cause.
// [RULE_20] Polarity bit selects output level, low after reset.
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
module udi_device #(
  parameter int SUSPEND_CYCLES = udi_pkg::SUSPEND_CYCLES_DEF,
  parameter int RESET_CYCLES = udi_pkg::BUS_RESET_CYCLES
) (
  input wire logic mclk,
  input wire logic arst_n,
  udi_bus_if.dev bus,
  input wire logic setup_stored,
  input wire logic [2:0] rx_pkt_done,
  input wire logic [3:0] tx_fifo_ready,
  input wire logic line_se0,
  input wire logic line_idle,
  input wire logic resume_seen,
  output logic [2:0] rx_pkt_held,
  output logic [3:0] tx_pkt_armed,
  output logic suspended
);
  localparam int IW = $clog2(SUSPEND_CYCLES + 1);
  localparam int RW = $clog2(RESET_CYCLES + 1);
  localparam logic [IW-1:0] IDLE_LAST = IW'(SUSPEND_CYCLES - 1);
  localparam logic [RW-1:0] SE0_LAST = RW'(RESET_CYCLES - 1);
  localparam logic [IW-1:0] IDLE_FULL = IW'(SUSPEND_CYCLES);
  localparam logic [RW-1:0] SE0_FULL = RW'(RESET_CYCLES);

  logic [7:0] cause_reg;
  logic [7:0] mask_reg;
  logic [7:0] pkt_reg;
  logic setup_reg;
  logic busrst_reg;
  logic susp_reg;
  logic pol_reg;
  logic irq_reg;
  logic [7:0] rdata_reg;
  logic [IW-1:0] idle_cnt_reg;
  logic [RW-1:0] se0_cnt_reg;

  // Register decode.
  wire wr_mask = bus.wr && (bus.addr == udi_pkg::ADDR_MASK);
  wire wr_ep0 = bus.wr && (bus.addr == udi_pkg::ADDR_EP0STATE);
  wire wr_pkt = bus.wr && (bus.addr == udi_pkg::ADDR_PACKET_READY_FLAGS);
  wire wr_dev = bus.wr && (bus.addr == udi_pkg::ADDR_DEVSTATE);
  wire wr_pol = bus.wr && (bus.addr == udi_pkg::ADDR_POLARITY_SELECT_REG);
  wire wr_sys = bus.wr && (bus.addr == udi_pkg::ADDR_SYSCTL);
  // Software reset acts as the hardware reset on every register except rdata_reg, at the clock edge that takes the write.
  wire soft_rst = wr_sys && bus.wdata[udi_pkg::SYSCTL_SRST_BIT];
  wire [7:0] pkt_sw = wr_pkt ? bus.wdata : 8'h00;

  // Line timers.
  wire se0_hit = line_se0 && (se0_cnt_reg == SE0_LAST);
  wire idle_hit = line_idle && (idle_cnt_reg == IDLE_LAST) && !susp_reg;
  // Counters stop one past the threshold, so a long run raises its event only once.
  wire [RW-1:0] se0_cnt_next = !line_se0 ? '0 :
                               (se0_cnt_reg == SE0_FULL) ? se0_cnt_reg :
                               se0_cnt_reg + RW'(1);
  wire [IW-1:0] idle_cnt_next = !line_idle ? '0 :
                                (idle_cnt_reg == IDLE_FULL) ? idle_cnt_reg :
                                idle_cnt_reg + IW'(1);
  wire reset_event = se0_hit; // RULE_16
  wire suspend_event = idle_hit; // RULE_18

  // Flags of the endpoint and device state registers.
  wire setup_next = setup_stored || (setup_reg && !(wr_ep0 && bus.wdata[udi_pkg::EP0_SETUP_BIT])); // RULE_05 RULE_06
  wire [7:0] pkt_keep = pkt_reg & ~(pkt_sw & udi_pkg::PKT_RX_BITS) & ~{tx_fifo_ready, 4'h0}; // RULE_09 RULE_12
  wire [7:0] pkt_next = pkt_keep | {5'h00, rx_pkt_done} | (pkt_sw & udi_pkg::PKT_TX_BITS); // RULE_08 RULE_10 RULE_13
  wire busrst_next = reset_event || (busrst_reg && !(wr_dev && bus.wdata[udi_pkg::DEV_BUSRST_BIT])); // RULE_17
  wire susp_next = suspend_event || (susp_reg && !resume_seen && !reset_event); // RULE_18 RULE_19

  // Cause events and clears.
  logic [7:0] cause_ev;
  logic [7:0] cause_clr;
  always_comb
  begin
    cause_ev = 8'h00;
    cause_clr = 8'h00;
    cause_ev[udi_pkg::CAUSE_SETUP] = setup_stored; // RULE_01 RULE_05
    cause_ev[udi_pkg::CAUSE_EP0_RX] = rx_pkt_done[0]; // RULE_11
    cause_ev[udi_pkg::CAUSE_EP1] = rx_pkt_done[1] || tx_fifo_ready[1]; // RULE_11 RULE_15
    cause_ev[udi_pkg::CAUSE_EP2] = rx_pkt_done[2] || tx_fifo_ready[2]; // RULE_11 RULE_15
    cause_ev[udi_pkg::CAUSE_EP0_TX] = tx_fifo_ready[0]; // RULE_15
    cause_ev[udi_pkg::CAUSE_EP3] = tx_fifo_ready[3]; // RULE_15
    cause_ev[udi_pkg::CAUSE_BUS_RESET] = reset_event; // RULE_16
    cause_ev[udi_pkg::CAUSE_SUSPEND] = suspend_event; // RULE_18
    cause_clr[udi_pkg::CAUSE_SETUP] = wr_ep0 && bus.wdata[udi_pkg::EP0_SETUP_BIT]; // RULE_06
    cause_clr[udi_pkg::CAUSE_EP0_RX] = pkt_sw[0]; // RULE_09
    cause_clr[udi_pkg::CAUSE_EP1] = pkt_sw[1] || pkt_sw[udi_pkg::PKT_TX_BASE + 1]; // RULE_09 RULE_13
    cause_clr[udi_pkg::CAUSE_EP2] = pkt_sw[2] || pkt_sw[udi_pkg::PKT_TX_BASE + 2]; // RULE_09 RULE_13
    cause_clr[udi_pkg::CAUSE_EP0_TX] = pkt_sw[udi_pkg::PKT_TX_BASE]; // RULE_13
    cause_clr[udi_pkg::CAUSE_EP3] = pkt_sw[udi_pkg::PKT_TX_BASE + 3]; // RULE_13
    cause_clr[udi_pkg::CAUSE_BUS_RESET] = wr_dev && bus.wdata[udi_pkg::DEV_BUSRST_BIT]; // RULE_17
    cause_clr[udi_pkg::CAUSE_SUSPEND] = resume_seen || reset_event; // RULE_19
  end

  wire [7:0] mask_next = wr_mask ? bus.wdata : mask_reg; // RULE_02
  // A new event wins over a clear in the same cycle; disabled bits are forced to zero.
  wire [7:0] cause_next = ((cause_reg & ~cause_clr) | cause_ev) & mask_next; // RULE_01 RULE_03
  wire pol_next = wr_pol ? bus.wdata[udi_pkg::POL_HIGH_BIT] : pol_reg;
  wire cause_any = |cause_next;
  wire irq_next = pol_next ? cause_any : !cause_any; // RULE_04 RULE_20

  // Read path; unmapped addresses and reserved bits read zero.
  wire [7:0] ep0_rd = {7'h00, setup_reg};
  wire [7:0] dev_rd = {1'b0, susp_reg, busrst_reg, 5'h00};
  wire [7:0] pol_rd = {7'h00, pol_reg};
  wire [7:0] rd_mux = (bus.addr == udi_pkg::ADDR_CAUSE) ? cause_reg :
                      (bus.addr == udi_pkg::ADDR_MASK) ? mask_reg :
                      (bus.addr == udi_pkg::ADDR_EP0STATE) ? ep0_rd :
                      (bus.addr == udi_pkg::ADDR_PACKET_READY_FLAGS) ? pkt_reg :
                      (bus.addr == udi_pkg::ADDR_DEVSTATE) ? dev_rd :
                      (bus.addr == udi_pkg::ADDR_POLARITY_SELECT_REG) ? pol_rd :
                      8'h00;
  wire [7:0] rdata_next = bus.rd ? rd_mux : 8'h00;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cause_reg <= udi_pkg::CAUSE_RESET;
      mask_reg <= udi_pkg::MASK_RESET; // RULE_07
      pol_reg <= udi_pkg::POL_RESET; // RULE_20
      irq_reg <= udi_pkg::IRQ_IDLE_LOW_ACTIVE;
    end
    else if (soft_rst)
    begin
      cause_reg <= udi_pkg::CAUSE_RESET;
      mask_reg <= udi_pkg::MASK_RESET; // RULE_07
      pol_reg <= udi_pkg::POL_RESET; // RULE_20
      irq_reg <= udi_pkg::IRQ_IDLE_LOW_ACTIVE;
    end
    else
    begin
      cause_reg <= cause_next;
      mask_reg <= mask_next;
      pol_reg <= pol_next;
      irq_reg <= irq_next;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pkt_reg <= udi_pkg::PKT_RESET;
      setup_reg <= 1'b0;
      busrst_reg <= 1'b0;
      susp_reg <= 1'b0;
    end
    else if (soft_rst)
    begin
      pkt_reg <= udi_pkg::PKT_RESET;
      setup_reg <= 1'b0;
      busrst_reg <= 1'b0;
      susp_reg <= 1'b0;
    end
    else
    begin
      pkt_reg <= pkt_next;
      setup_reg <= setup_next;
      busrst_reg <= busrst_next;
      susp_reg <= susp_next;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      se0_cnt_reg <= '0;
      idle_cnt_reg <= '0;
    end
    else if (soft_rst)
    begin
      se0_cnt_reg <= '0;
      idle_cnt_reg <= '0;
    end
    else
    begin
      se0_cnt_reg <= se0_cnt_next;
      idle_cnt_reg <= idle_cnt_next;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign bus.rdata = rdata_reg;
  assign bus.irq_out = irq_reg;
  assign rx_pkt_held = pkt_reg[2:0];
  // The transmitter sends whatever is in its FIFO once armed, full or short.
  assign tx_pkt_armed = pkt_reg[7:4]; // RULE_14
  assign suspended = susp_reg;
endmodule
`default_nettype wire

// ==== rtl/udi_pkg.sv ====
// Shared constants of the USB device interrupt unit and its microcontroller end.
package udi_pkg;
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 8;
  localparam logic [7:0] ADDR_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h01;
  localparam logic [7:0] ADDR_EP0STATE = 8'h02;
  localparam logic [7:0] ADDR_PACKET_READY_FLAGS = 8'h03;
  localparam logic [7:0] ADDR_DEVSTATE = 8'h04;
  localparam logic [7:0] ADDR_POLARITY_SELECT_REG = 8'h05;
  localparam logic [7:0] ADDR_SYSCTL = 8'h06;
  localparam int CAUSE_SETUP = 0;
  localparam int CAUSE_EP1 = 1;
  localparam int CAUSE_EP2 = 2;
  localparam int CAUSE_EP0_RX = 3;
  localparam int CAUSE_EP0_TX = 4;
  localparam int CAUSE_BUS_RESET = 5;
  localparam int CAUSE_SUSPEND = 6;
  localparam int CAUSE_EP3 = 7;
  localparam int EP0_SETUP_BIT = 0;
  localparam int PKT_TX_BASE = 4;
  localparam logic [7:0] PKT_RX_BITS = 8'h07;
  localparam logic [7:0] PKT_TX_BITS = 8'hF0;
  localparam int DEV_BUSRST_BIT = 5;
  localparam int DEV_SUSPEND_BIT = 6;
  localparam int POL_HIGH_BIT = 0;
  localparam int SYSCTL_SRST_BIT = 0;
  localparam logic [7:0] MASK_RESET = 8'h01;
  localparam logic [7:0] CAUSE_RESET = 8'h00;
  localparam logic [7:0] PKT_RESET = 8'h00;
  localparam logic POL_RESET = 1'b0;
  localparam logic IRQ_IDLE_LOW_ACTIVE = 1'b1;
  localparam int CLK_PERIOD_NS = 25;
  localparam int BUS_RESET_SE0_NS = 2500;
  localparam int BUS_RESET_CYCLES = (BUS_RESET_SE0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUSPEND_IDLE_US = 3000;
  localparam int SUSPEND_CYCLES_DEF = (SUSPEND_IDLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] HREG_ADDR = 3'h0;
  localparam logic [2:0] HREG_DATA = 3'h1;
  localparam logic [2:0] HREG_GO = 3'h2;
  localparam logic [2:0] HREG_RESULT = 3'h3;
  localparam logic [2:0] HREG_STAT = 3'h4;
  localparam int GO_WRITE_BIT = 0;
  localparam int GO_READ_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;
  typedef enum logic [1:0] {UDI_H_IDLE, UDI_H_WRITE, UDI_H_READ, UDI_H_CAPTURE} udi_host_state_t;
endpackage

// ==== rtl/udi_bus_if.sv ====
// Local bus and interrupt line between the interrupt unit and the microcontroller.
`timescale 1ns/10ps
`default_nettype none
interface udi_bus_if;
  logic [udi_pkg::BUS_AW-1:0] addr;
  logic [udi_pkg::BUS_DW-1:0] wdata;
  logic [udi_pkg::BUS_DW-1:0] rdata;
  logic wr;
  logic rd;
  logic irq_out;
  modport dev (
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata,
    output irq_out
  );
  modport mcu (
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata,
    input irq_out
  );
endinterface
`default_nettype wire

// ==== rtl/udi_mcu.sv ====
// Microcontroller end: runs local bus cycles on command and watches the interrupt line.
`timescale 1ns/10ps
`default_nettype none
module udi_mcu (
  input wire logic mclk,
  input wire logic arst_n,
  udi_bus_if.mcu bus,
  input wire logic [2:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  output logic irq_seen
);
  udi_pkg::udi_host_state_t state_reg;
  udi_pkg::udi_host_state_t state_next;
  logic [7:0] addr_reg;
  logic [7:0] data_reg;
  logic [7:0] result_reg;
  logic pol_reg;
  logic irq_reg;
  logic [7:0] sw_rdata_reg;

  wire busy = (state_reg != udi_pkg::UDI_H_IDLE);
  wire wr_addr = sw_wr && !busy && (sw_addr == udi_pkg::HREG_ADDR);
  wire wr_data = sw_wr && !busy && (sw_addr == udi_pkg::HREG_DATA);
  wire wr_go = sw_wr && !busy && (sw_addr == udi_pkg::HREG_GO);
  wire go_write = wr_go && sw_wdata[udi_pkg::GO_WRITE_BIT];
  wire go_read = wr_go && !sw_wdata[udi_pkg::GO_WRITE_BIT] && sw_wdata[udi_pkg::GO_READ_BIT];
  wire issue_wr = (state_reg == udi_pkg::UDI_H_WRITE);
  // Track the polarity the device was told to use, so the line can be decoded.
  wire pol_wr = issue_wr && (addr_reg == udi_pkg::ADDR_POLARITY_SELECT_REG);
  wire srst_wr = issue_wr && (addr_reg == udi_pkg::ADDR_SYSCTL) &&
                 data_reg[udi_pkg::SYSCTL_SRST_BIT];
  wire pol_next = srst_wr ? udi_pkg::POL_RESET :
                  pol_wr ? data_reg[udi_pkg::POL_HIGH_BIT] : pol_reg; // RULE_20
  wire irq_next = pol_reg ? bus.irq_out : !bus.irq_out; // RULE_04
  wire [7:0] stat_rd = {6'h00, irq_reg, busy};
  wire [7:0] rd_mux = (sw_addr == udi_pkg::HREG_ADDR) ? addr_reg :
                      (sw_addr == udi_pkg::HREG_DATA) ? data_reg :
                      (sw_addr == udi_pkg::HREG_RESULT) ? result_reg :
                      (sw_addr == udi_pkg::HREG_STAT) ? stat_rd :
                      8'h00;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      udi_pkg::UDI_H_IDLE:
      begin
        if (go_write)
          state_next = udi_pkg::UDI_H_WRITE;
        else if (go_read)
          state_next = udi_pkg::UDI_H_READ;
      end
      udi_pkg::UDI_H_WRITE: state_next = udi_pkg::UDI_H_IDLE;
      udi_pkg::UDI_H_READ: state_next = udi_pkg::UDI_H_CAPTURE;
      udi_pkg::UDI_H_CAPTURE: state_next = udi_pkg::UDI_H_IDLE;
      default: state_next = udi_pkg::UDI_H_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= udi_pkg::UDI_H_IDLE;
      addr_reg <= 8'h00;
      data_reg <= 8'h00;
      result_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      addr_reg <= wr_addr ? sw_wdata : addr_reg;
      data_reg <= wr_data ? sw_wdata : data_reg;
      result_reg <= (state_reg == udi_pkg::UDI_H_CAPTURE) ? bus.rdata : result_reg;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pol_reg <= udi_pkg::POL_RESET;
      irq_reg <= 1'b0;
      sw_rdata_reg <= 8'h00;
    end
    else
    begin
      pol_reg <= pol_next;
      irq_reg <= irq_next;
      sw_rdata_reg <= sw_rd ? rd_mux : 8'h00;
    end
  end

  // Clearing a flag is done by software writing one to it; see ADDR_* map. RULE_06 RULE_09 RULE_13 RULE_17
  assign bus.addr = addr_reg;
  assign bus.wdata = data_reg;
  assign bus.wr = issue_wr;
  assign bus.rd = (state_reg == udi_pkg::UDI_H_READ);
  assign sw_rdata = sw_rdata_reg;
  assign irq_seen = irq_reg;
endmodule
`default_nettype wire

// ==== testbench/udi_bus_sva.sv ====
// Checker of the local bus and interrupt line between the two ends.
`timescale 1ns/10ps
`default_nettype none
module udi_bus_sva (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [udi_pkg::BUS_AW-1:0] addr,
  input wire logic [udi_pkg::BUS_DW-1:0] wdata,
  input wire logic [udi_pkg::BUS_DW-1:0] rdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic irq_out
);
  logic [7:0] mask_reg;
  logic pol_reg;
  wire soft_rst = wr && addr == udi_pkg::ADDR_SYSCTL && wdata[udi_pkg::SYSCTL_SRST_BIT];
  wire mask_wr = wr && addr == udi_pkg::ADDR_MASK;
  wire pol_wr = wr && addr == udi_pkg::ADDR_POLARITY_SELECT_REG;
  // Shadow copies of mask and polarity predict reads and the idle line level.
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mask_reg <= udi_pkg::MASK_RESET;
      pol_reg <= udi_pkg::POL_RESET;
    end
    else if (soft_rst)
    begin
      mask_reg <= udi_pkg::MASK_RESET;
      pol_reg <= udi_pkg::POL_RESET;
    end
    else if (mask_wr)
      mask_reg <= wdata;
    else if (pol_wr)
      pol_reg <= wdata[udi_pkg::POL_HIGH_BIT];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_rd(logic [7:0] a);
    rd && addr == a;
  endsequence
  property p_mask_read;
    s_rd(udi_pkg::ADDR_MASK) |=> rdata == mask_reg;
  endproperty
  property p_cause_masked;
    s_rd(udi_pkg::ADDR_CAUSE) |=> (rdata & ~mask_reg) == 8'h00;
  endproperty
  property p_irq_cause;
    s_rd(udi_pkg::ADDR_CAUSE) |=> ((rdata != 8'h00) == ($past(irq_out) == $past(pol_reg)));
  endproperty
  property p_reset_idle;
    !$past(arst_n) |-> irq_out;
  endproperty
  property p_soft_reset;
    soft_rst |=> irq_out;
  endproperty
  property p_mask_zero;
    mask_wr && wdata == 8'h00 |=> irq_out == !pol_reg;
  endproperty
  property p_pol_read;
    s_rd(udi_pkg::ADDR_POLARITY_SELECT_REG) |=> rdata == {7'h00, pol_reg};
  endproperty
  property p_pkt_gap;
    s_rd(udi_pkg::ADDR_PACKET_READY_FLAGS) |=> !rdata[3];
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read differs from last written value");
  a_cause_masked: assert property (p_cause_masked)
    else $error("cause bit set while disabled");
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt line disagrees with cause register");
  a_reset_idle: assert property (p_reset_idle)
    else $error("interrupt line not high after reset");
  a_soft_reset: assert property (p_soft_reset)
    else $error("interrupt line not idle after software reset");
  a_mask_zero: assert property (p_mask_zero)
    else $error("interrupt line active after mask cleared");
  a_pol_read: assert property (p_pol_read)
    else $error("polarity read differs from last written value");
  a_pkt_gap: assert property (p_pkt_gap)
    else $error("unused packet ready bit reads one");
endmodule
`default_nettype wire

// ==== testbench/test_usb_device_interrupt_unit.sv ====
// Testbench joining both ends of the interrupt unit over the local bus.
`timescale 1ns/10ps
`default_nettype none
module test_usb_device_interrupt_unit;
  localparam int SUSP = 20;
  localparam int RST = 4;
  localparam logic [7:0] RXC [0:2] = '{8'h08, 8'h02, 8'h04};
  localparam logic [7:0] TXC [0:3] = '{8'h10, 8'h02, 8'h04, 8'h80};
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [8:0] evt = 9'h000;
  logic [1:0] lv = 2'h0;
  logic [2:0] sw_addr = 3'h0;
  logic [7:0] sw_wdata = 8'h00;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [7:0] sw_rdata;
  logic irq_seen;
  logic [2:0] rx_held;
  logic [3:0] tx_armed;
  logic suspended;
  int failures = 0;
  int n_tests = 0;
  udi_bus_if bus ();
  udi_device #(.SUSPEND_CYCLES(SUSP), .RESET_CYCLES(RST)) u_udi_device (.mclk(mclk),
    .arst_n(arst_n), .bus(bus), .setup_stored(evt[0]), .rx_pkt_done(evt[3:1]),
    .tx_fifo_ready(evt[7:4]), .line_se0(lv[0]), .line_idle(lv[1]), .resume_seen(evt[8]),
    .rx_pkt_held(rx_held), .tx_pkt_armed(tx_armed), .suspended(suspended));
  udi_mcu u_udi_mcu (.mclk(mclk), .arst_n(arst_n), .bus(bus), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .irq_seen(irq_seen));
  udi_bus_sva u_udi_bus_sva (.mclk(mclk), .arst_n(arst_n), .addr(bus.addr),
    .wdata(bus.wdata), .rdata(bus.rdata), .wr(bus.wr), .rd(bus.rd), .irq_out(bus.irq_out));
  always #12.5 mclk = ~mclk;
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Line level: active state equals polarity bit, so level is one when they match.
  task automatic chk_irq(input logic act, input logic pol);
    chk({7'h00, bus.irq_out}, {7'h00, act ~^ pol});
  endtask
  task automatic sw_w(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_r(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge mclk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic dev_w(input logic [7:0] a, input logic [7:0] d);
    sw_w(udi_pkg::HREG_ADDR, a);
    sw_w(udi_pkg::HREG_DATA, d);
    sw_w(udi_pkg::HREG_GO, 8'h01);
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    sw_w(udi_pkg::HREG_ADDR, a);
    sw_w(udi_pkg::HREG_GO, 8'h02);
    repeat (2) @(posedge mclk);
    sw_r(udi_pkg::HREG_RESULT, d);
    chk(d, exp);
  endtask
  task automatic pulse(input int k);
    @(posedge mclk);
    evt[k] <= 1'b1;
    @(posedge mclk);
    evt[k] <= 1'b0;
  endtask
  task automatic hold(input int k, input int n);
    @(posedge mclk);
    lv[k] <= 1'b1;
    repeat (n) @(posedge mclk);
    lv[k] <= 1'b0;
  endtask
  task automatic t_reset();
    rc(udi_pkg::ADDR_MASK, 8'h01);
    rc(udi_pkg::ADDR_POLARITY_SELECT_REG, 8'h00);
    chk_irq(1'b0, 1'b0);
    rc(8'h3C, 8'h00);
    dev_w(udi_pkg::ADDR_CAUSE, 8'hFF);
    rc(udi_pkg::ADDR_CAUSE, 8'h00);
  endtask
  task automatic t_setup();
    pulse(0);
    rc(udi_pkg::ADDR_CAUSE, 8'h01);
    rc(udi_pkg::ADDR_EP0STATE, 8'h01);
    chk_irq(1'b1, 1'b0);
    dev_w(udi_pkg::ADDR_EP0STATE, 8'h01);
    rc(udi_pkg::ADDR_CAUSE, 8'h00);
    rc(udi_pkg::ADDR_EP0STATE, 8'h00);
    chk_irq(1'b0, 1'b0);
  endtask
  task automatic t_rx();
    dev_w(udi_pkg::ADDR_MASK, 8'hFF);
    for (int ep = 0; ep < 3; ep++)
    begin
      pulse(1 + ep);
      rc(udi_pkg::ADDR_CAUSE, RXC[ep]);
      rc(udi_pkg::ADDR_PACKET_READY_FLAGS, 8'h01 << ep);
      chk({5'h00, rx_held}, 8'h01 << ep);
      dev_w(udi_pkg::ADDR_PACKET_READY_FLAGS, 8'h01 << ep);
      rc(udi_pkg::ADDR_CAUSE, 8'h00);
    end
  endtask
  task automatic t_tx();
    dev_w(udi_pkg::ADDR_PACKET_READY_FLAGS, 8'hF0);
    chk({4'h0, tx_armed}, 8'h0F);
    for (int ep = 0; ep < 4; ep++)
    begin
      pulse(4 + ep);
      rc(udi_pkg::ADDR_CAUSE, TXC[ep]);
      chk({4'h0, tx_armed}, 8'h0F ^ (8'h01 << ep));
      dev_w(udi_pkg::ADDR_PACKET_READY_FLAGS, 8'h10 << ep);
      rc(udi_pkg::ADDR_CAUSE, 8'h00);
      chk({4'h0, tx_armed}, 8'h0F);
    end
  endtask
  task automatic t_mask();
    dev_w(udi_pkg::ADDR_MASK, 8'hF7);
    pulse(1);
    rc(udi_pkg::ADDR_CAUSE, 8'h00);
    rc(udi_pkg::ADDR_PACKET_READY_FLAGS, 8'hF1);
    dev_w(udi_pkg::ADDR_PACKET_READY_FLAGS, 8'h01);
    dev_w(udi_pkg::ADDR_MASK, 8'hFF);
    pulse(2);
    dev_w(udi_pkg::ADDR_MASK, 8'hFD);
    rc(udi_pkg::ADDR_CAUSE, 8'h00);
    chk_irq(1'b0, 1'b0);
    dev_w(udi_pkg::ADDR_PACKET_READY_FLAGS, 8'h02);
    pulse(0);
    dev_w(udi_pkg::ADDR_MASK, 8'h00);
    rc(udi_pkg::ADDR_CAUSE, 8'h00);
    chk_irq(1'b0, 1'b0);
    dev_w(udi_pkg::ADDR_EP0STATE, 8'h01);
    dev_w(udi_pkg::ADDR_MASK, 8'hFF);
  endtask
  task automatic t_busrst();
    hold(0, RST - 1);
    rc(udi_pkg::ADDR_CAUSE, 8'h00);
    hold(0, RST);
    rc(udi_pkg::ADDR_CAUSE, 8'h20);
    rc(udi_pkg::ADDR_DEVSTATE, 8'h20);
    dev_w(udi_pkg::ADDR_DEVSTATE, 8'h20);
    rc(udi_pkg::ADDR_CAUSE, 8'h00);
    rc(udi_pkg::ADDR_DEVSTATE, 8'h00);
    chk_irq(1'b0, 1'b0);
  endtask
  task automatic t_susp();
    hold(1, SUSP);
    rc(udi_pkg::ADDR_CAUSE, 8'h40);
    chk({7'h00, suspended}, 8'h01);
    pulse(8);
    rc(udi_pkg::ADDR_CAUSE, 8'h00);
    chk({7'h00, suspended}, 8'h00);
    hold(1, SUSP);
    hold(0, RST);
    rc(udi_pkg::ADDR_CAUSE, 8'h20);
    dev_w(udi_pkg::ADDR_DEVSTATE, 8'h20);
  endtask
  task automatic t_pol();
    pulse(0);
    dev_w(udi_pkg::ADDR_POLARITY_SELECT_REG, 8'h01);
    chk_irq(1'b1, 1'b1);
    chk({7'h00, irq_seen}, 8'h01);
    dev_w(udi_pkg::ADDR_SYSCTL, 8'h01);
    rc(udi_pkg::ADDR_MASK, 8'h01);
    rc(udi_pkg::ADDR_CAUSE, 8'h00);
    chk_irq(1'b0, 1'b0);
  endtask
  initial
  begin
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_setup();
    t_rx();
    t_tx();
    t_mask();
    t_busrst();
    t_susp();
    t_pol();
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
